/* rtl/pasb_pkg.sv */
/*
 * pasb_pkg: constants shared by the parallel-result to serial bridge.
 * assumes: a 200 MHz system clock and a host-driven serial clock.
 */
package pasb_pkg;

    // ---------------------------------------------------------------
    // word and counter geometry
    // ---------------------------------------------------------------
    localparam int DATA_W    = 16;  // converter result width
    localparam int CNT_W     = 3;   // clock-pair counter width
    localparam int IDX_W     = 4;   // counter plus half-clock bit
    localparam int BUF_DEPTH = 2;   // result buffer entries
    localparam int SYNC_LEN  = 2;   // synchroniser stages

    // ---------------------------------------------------------------
    // frame clock index decode (index = clocks seen minus one)
    // ---------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_FIRST   = 4'h0;  // first rising edge
    localparam logic [IDX_W-1:0] IDX_ONE     = 4'h1;  // count step
    localparam logic [IDX_W-1:0] IDX_CONV_HI = 4'h7;  // eighth clock
    localparam logic [IDX_W-1:0] IDX_CONV_LO = 4'hE;  // fifteenth clock
    localparam logic [IDX_W-1:0] IDX_STOP    = 4'hF;  // sixteenth clock

    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [DATA_W-1:0] WORD_RST = 16'h0000;
    localparam logic              CONV_RST = 1'b0;

    // ---------------------------------------------------------------
    // host frame timing, kept for reference by the bench
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS      = 5;
    localparam int MIN_FRAME_PERIOD   = 500;  // ns, least frame length
    localparam int MIN_FRAME_CYCLES   =
        (MIN_FRAME_PERIOD + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

/* rtl/pasb_bridge.sv */
/*
 * pasb_bridge: makes a parallel-output converter look like a serial
 * converter. the host drives chip select and the serial clock; the
 * bridge shifts the captured result out msb first and makes the
 * active-low conversion start pulse.
 * assumes: sclk stands still or runs outside frames, cs_n is driven
 * by the host, the result bus is stable while a conversion is idle.
 */
// What this block does
// - drive serial output only while select low
// - first serial clock is first falling edge
// - msb visible right after select falls
// - later bits change after rising edges
// - shift register loads word or shifts
// - serial output is top register bit once started
// - select high keeps loading, blocks shifting
// - falling-edge flop of inverted select enables
// - 3-bit counter, select reset, and-decode stop
// - counter stops after sixteenth clock
// - start high clocks eight to fifteen
// - parallel result in, start out
module pasb_bridge
    import pasb_pkg::*;
#(
    parameter int WORD_W = DATA_W,     // result width
    parameter int DEPTH  = BUF_DEPTH   // result buffer entries
) (
    input  wire logic              clk,                  // system clock
    input  wire logic              rst,                  // sync, high
    input  wire logic              sclk,                 // host clock
    input  wire logic              cs_n,                 // host select
    input  wire logic [WORD_W-1:0] parallel_result_bus,  // converter
    output logic                   conversion_start_n,   // to converter
    output logic                   serial_data_out,      // serial data
    output logic                   serial_data_oe        // drive enable
);

    // ---------------------------------------------------------------
    // elaboration checks
    // ---------------------------------------------------------------
    // the clock counter decode is built for exactly one 16-bit word
    if (WORD_W != DATA_W) begin : g_bad_width
        $error("pasb_bridge: word width must match the counter decode");
    end
    if (DEPTH < 2) begin : g_bad_depth
        $error("pasb_bridge: buffer needs at least two entries");
    end

    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_BITS = $clog2(DEPTH + 1);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
    localparam logic [PTR_W-1:0] PTR_ZERO = '0;
    localparam logic [CNT_BITS-1:0] CNT_FULL = CNT_BITS'(DEPTH);
    localparam logic [CNT_BITS-1:0] CNT_ZERO = '0;
    localparam logic [CNT_BITS-1:0] CNT_ONE  = CNT_BITS'(1);

    // ---------------------------------------------------------------
    // pin synchronisers (system clock)
    // ---------------------------------------------------------------
    logic [SYNC_LEN-1:0] cs_sync_r;      // select, two stages
    logic [WORD_W-1:0]   res_s1_r;       // result, first stage
    logic [WORD_W-1:0]   res_s2_r;       // result, second stage
    logic                sel_idle;       // select high, synced

    // only the second stages are read by logic beyond this point
    always_ff @(posedge clk) begin
        if (rst) begin
            cs_sync_r <= '1;
            res_s1_r  <= WORD_RST;
            res_s2_r  <= WORD_RST;
        end else begin
            cs_sync_r <= {cs_sync_r[0], cs_n};
            res_s1_r  <= parallel_result_bus;
            res_s2_r  <= res_s1_r;
        end
    end

    assign sel_idle = cs_sync_r[SYNC_LEN-1];

    // ---------------------------------------------------------------
    // result buffer (system clock)
    // ---------------------------------------------------------------
    logic [WORD_W-1:0]   buf_mem_r [DEPTH];   // entries
    logic [WORD_W-1:0]   buf_mem_nxt [DEPTH];
    logic [PTR_W-1:0]    wr_ptr_r, wr_ptr_nxt;
    logic [PTR_W-1:0]    rd_ptr_r, rd_ptr_nxt;
    logic [CNT_BITS-1:0] fill_r, fill_nxt;     // words held
    logic                in_valid;             // sampler offers word
    logic                in_ready;             // room for a word
    logic                out_valid;            // head word present
    logic                out_ready;            // holder accepts head
    logic                push, pop;

    // the sampler offers a word every cycle while select is high;
    // the holder drains only then, so during a frame the buffer
    // neither fills nor drains and the sampler offers no words
    assign in_valid  = sel_idle;
    assign in_ready  = (fill_r != CNT_FULL);
    assign out_valid = (fill_r != CNT_ZERO);
    assign out_ready = sel_idle;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // next pointers, fill level and entries
    always_comb begin
        buf_mem_nxt = buf_mem_r;
        wr_ptr_nxt  = wr_ptr_r;
        rd_ptr_nxt  = rd_ptr_r;
        fill_nxt    = fill_r;
        if (push) begin
            buf_mem_nxt[wr_ptr_r] = res_s2_r;
            wr_ptr_nxt = (wr_ptr_r == PTR_LAST) ? PTR_ZERO
                                                : wr_ptr_r + PTR_W'(1);
        end
        if (pop) begin
            rd_ptr_nxt = (rd_ptr_r == PTR_LAST) ? PTR_ZERO
                                                : rd_ptr_r + PTR_W'(1);
        end
        if (push && !pop) begin
            fill_nxt = fill_r + CNT_ONE;
        end else if (pop && !push) begin
            fill_nxt = fill_r - CNT_ONE;
        end
    end

    // buffer registers
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_r <= PTR_ZERO;
            rd_ptr_r <= PTR_ZERO;
            fill_r   <= CNT_ZERO;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            fill_r   <= fill_nxt;
        end
        buf_mem_r <= buf_mem_nxt;   // data needs no reset
    end

    // ---------------------------------------------------------------
    // captured word holder (system clock)
    // ---------------------------------------------------------------
    // holds the word the next frame sends; it freezes while select is
    // low so the link side may read it as a static word. the word in
    // hand at select fall is the result of the conversion that the
    // previous frame started
    logic [WORD_W-1:0] cap_word_r, cap_word_nxt;

    always_comb begin
        cap_word_nxt = cap_word_r;
        if (pop) begin
            cap_word_nxt = buf_mem_r[rd_ptr_r];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cap_word_r <= WORD_RST;
        end else begin
            cap_word_r <= cap_word_nxt;
        end
    end

    // ---------------------------------------------------------------
    // frame enable (serial clock, falling edge)
    // ---------------------------------------------------------------
    // samples inverted select on falling edges, so the first falling
    // edge after select falls opens the frame; select high clears it
    // at once because the serial clock may already have stopped
    logic en_r;

    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            en_r <= 1'b0;
        end else begin
            en_r <= ~cs_n;
        end
    end

    // ---------------------------------------------------------------
    // shift register and clock counter (serial clock, rising edge)
    // ---------------------------------------------------------------
    logic [WORD_W-1:0] shreg_r, shreg_nxt;   // outgoing bits
    logic              started_r, started_nxt; // first rise seen
    logic [CNT_W-1:0]  pair_cnt_r;            // 3-bit counter
    logic              half_r;                // half of a pair
    logic [IDX_W-1:0]  idx, idx_nxt;          // clock index
    logic              conv_n_r, conv_n_nxt;  // start, registered
    logic              stopped;               // index at stop

    assign idx     = {pair_cnt_r, half_r};
    assign stopped = &idx;

    // next shift, count and start values
    always_comb begin
        shreg_nxt   = shreg_r;
        started_nxt = started_r;
        idx_nxt     = idx;
        if (!en_r) begin
            // no frame clock yet: load, do not shift
            shreg_nxt   = cap_word_r;
            started_nxt = 1'b0;
            idx_nxt     = IDX_FIRST;
        end else if (!started_r) begin
            // first rising edge keeps the msb already shown
            shreg_nxt   = cap_word_r;
            started_nxt = 1'b1;
            idx_nxt     = IDX_FIRST;
        end else begin
            // later rising edges move the next bit to the top
            shreg_nxt = {shreg_r[WORD_W-2:0], 1'b0};
            if (!stopped) begin
                idx_nxt = idx + IDX_ONE;
            end
        end
        // high from the eighth through fifteenth clock, low at the
        // sixteenth, which starts the next conversion
        conv_n_nxt = (idx_nxt >= IDX_CONV_HI) &&
                     (idx_nxt <= IDX_CONV_LO);
    end

    // select high resets the counter and frame state
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            started_r  <= 1'b0;
            pair_cnt_r <= '0;
            half_r     <= 1'b0;
            conv_n_r   <= CONV_RST;
        end else begin
            started_r  <= started_nxt;
            pair_cnt_r <= idx_nxt[IDX_W-1:1];
            half_r     <= idx_nxt[0];
            conv_n_r   <= conv_n_nxt;
        end
    end

    // the word itself needs no reset; it is reloaded every frame
    always_ff @(posedge sclk) begin
        shreg_r <= shreg_nxt;
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    // before the first rising edge the msb comes straight from the
    // frozen holder so it shows without any serial clock edge
    assign serial_data_out = started_r ? shreg_r[WORD_W-1]
                                       : cap_word_r[WORD_W-1];
    assign serial_data_oe     = ~cs_n;
    assign conversion_start_n = conv_n_r;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    a_out_tristate: assert property (
        @(posedge clk) disable iff (rst)
        cs_n |-> !serial_data_oe && $past(cs_n) == !$past(serial_data_oe)
    ) else $error("serial output driven while select high");

    a_msb_first: assert property (
        @(posedge sclk) disable iff (cs_n)
        !started_r |-> serial_data_out == cap_word_r[WORD_W-1]
    ) else $error("msb not shown before first rising edge");

    a_first_load: assert property (
        @(posedge sclk) disable iff (cs_n)
        $rose(started_r) |-> shreg_r == $past(cap_word_r) && $past(en_r)
    ) else $error("first rising edge did not keep the loaded word");

    a_shift_step: assert property (
        @(posedge sclk) disable iff (cs_n)
        started_r && $past(started_r) |->
            shreg_r == {$past(shreg_r[WORD_W-2:0]), 1'b0}
    ) else $error("shift register did not move one place");

    a_enable_order: assert property (
        @(posedge sclk) disable iff (cs_n)
        started_r |-> en_r
    ) else $error("shifting without frame enable");

    a_count_step: assert property (
        @(posedge sclk) disable iff (cs_n)
        started_r && $past(started_r) && $past(idx) != IDX_STOP |->
            idx == $past(idx) + IDX_ONE
    ) else $error("clock counter skipped a clock");

    a_count_stop: assert property (
        @(posedge sclk) disable iff (cs_n)
        idx == IDX_STOP |=> idx == IDX_STOP && !conversion_start_n
    ) else $error("counter left the stopped state");

    a_conv_window: assert property (
        @(posedge sclk) disable iff (cs_n)
        started_r |-> conversion_start_n ==
            (idx >= IDX_CONV_HI && idx <= IDX_CONV_LO)
    ) else $error("start pulse outside clocks eight to fifteen");

    a_hold_frozen: assert property (
        @(posedge clk) disable iff (rst)
        !sel_idle |=> $stable(cap_word_r)
    ) else $error("held word changed during a frame");

    a_load_refresh: assert property (
        @(posedge clk) disable iff (rst)
        sel_idle && out_valid |=> cap_word_r == $past(buf_mem_r[rd_ptr_r])
    ) else $error("held word not refreshed while select high");

    a_buf_bound: assert property (
        @(posedge clk) disable iff (rst)
        (fill_r <= CNT_FULL) and (push |-> fill_r != CNT_FULL)
    ) else $error("buffer overfilled");

endmodule

/* tb/pasb_conv_model.sv */
/*
 * pasb_conv_model: behavioural stand-in for the parallel converter.
 * assumes: a conversion starts on each fall of conversion_start_n and the
 * bench hands over the sample and the conversion length beforehand.
 */
module pasb_conv_model
    import pasb_pkg::*;
#(
    parameter logic [DATA_W-1:0] INIT_WORD = 16'hA5C3  // power-up result, arbitrary
) (
    input  wire logic              clk,                 // system clock
    input  wire logic              conversion_start_n,  // from the bridge
    input  wire logic [DATA_W-1:0] next_word,           // sample to return
    input  wire logic [7:0]        conv_cycles,         // conversion length in clk
    output logic [DATA_W-1:0]      parallel_result_bus  // result lines
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [DATA_W-1:0] word_r;   // sample taken at start
    int                left;     // cycles to completion, 0 = idle
    logic              start_d;  // previous start level

    initial begin
        parallel_result_bus = INIT_WORD;
        left = 0;
        start_d = 1'b0;
    end

    // ---------------------------------------------------------------
    // conversion
    // ---------------------------------------------------------------
    // the old result stands until the slow conversion ends, as a real part would
    always @(posedge clk) begin
        start_d <= conversion_start_n;
        if (start_d && !conversion_start_n) begin
            word_r <= next_word;
            left   <= conv_cycles + 1;
        end else if (left == 1) begin
            parallel_result_bus <= word_r;
            left <= 0;
        end else if (left > 1) begin
            left <= left - 1;
        end
    end
endmodule

/* tb/parallel_adc_serial_bridge_test.sv */
/*
 * parallel_adc_serial_bridge_test: self-checking bench for the bridge.
 * assumes: the bench plays the host master, sclk idles high and runs
 * at 30 ns inside frames and for four clocks after each; a converter model feeds the result bus.
 */
module parallel_adc_serial_bridge_test
    import pasb_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic              clk;                  // system clock
    logic              rst;                  // sync reset
    logic              sclk;                 // host serial clock
    logic              cs_n;                 // host select
    logic [DATA_W-1:0] next_word;            // sample for the model
    logic [7:0]        conv_cycles;          // model conversion length
    logic [DATA_W-1:0] parallel_result_bus;  // model to bridge
    logic              conversion_start_n;   // bridge to model
    logic              serial_data_out;      // bridge data
    logic              serial_data_oe;       // bridge drive enable
    logic              sdo_fill = 1'b0;      // changing level of a released line
    logic              sdo_line;             // resolved serial line
    logic [DATA_W-1:0] exp_word;             // word the next frame must return
    int                bad_count;            // mismatches
    int                cmp_count;            // comparisons
    int                nclk;                 // clocks in this frame
    int                nclk_tab [4] = '{16, 7, 20, 8};  // hand corner cases

    // a released line shows no stale bit
    assign sdo_line = serial_data_oe ? serial_data_out : sdo_fill;

    always @(posedge clk) begin
        sdo_fill <= ~sdo_fill;
    end

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    pasb_bridge dut (
        .clk                 (clk),
        .rst                 (rst),
        .sclk                (sclk),
        .cs_n                (cs_n),
        .parallel_result_bus (parallel_result_bus),
        .conversion_start_n  (conversion_start_n),
        .serial_data_out     (serial_data_out),
        .serial_data_oe      (serial_data_oe)
    );

    pasb_conv_model u_conv (
        .clk                 (clk),
        .conversion_start_n  (conversion_start_n),
        .next_word           (next_word),
        .conv_cycles         (conv_cycles),
        .parallel_result_bus (parallel_result_bus)
    );

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
                         input string what);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // one host frame of n clocks, falling edge first, sampled 5 ns after each rise
    task automatic frame(input int n, input logic [DATA_W-1:0] word);
        @(posedge clk);
        #1 cs_n = 1'b0;
        #2 check(sdo_line, word[15], "msb at select fall");
        check(serial_data_oe, 1'b1, "drive while selected");
        #17.3;
        for (int k = 1; k <= n; k++) begin
            sclk = 1'b0;
            #15 sclk = 1'b1;
            #5 check(sdo_line, (k <= 16) ? word[16-k] : 1'b0, "serial bit");
            check(conversion_start_n, logic'(k >= 8 && k <= 15), "start level");
            #10;
        end
        #10 @(posedge clk);
        #1 cs_n = 1'b1;
        #1 check(serial_data_oe, 1'b0, "release at select high");
        check(conversion_start_n, 1'b0, "counter cleared");
        // host keeps frames apart; clocks while deselected must do nothing
        repeat (4) begin
            sclk = 1'b0;
            #15 sclk = 1'b1;
            #15;
        end
        check(conversion_start_n, 1'b0, "no start while deselected");
        repeat (50) @(posedge clk);
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        rst = 1'b1;
        cs_n = 1'b0;
        sclk = 1'b1;
        next_word = 16'h0000;
        conv_cycles = 8'h02;
        bad_count = 0;
        cmp_count = 0;
        void'($urandom(64));
        // a clean select rise clears the serial-clock side, which has no reset
        #1 cs_n = 1'b1;
        // reset held for two clock cycles
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        repeat (60) @(posedge clk);
        exp_word = 16'hA5C3;
        for (int t = 0; t < 24; t++) begin
            @(posedge clk);
            #1;
            nclk = (t < 4) ? nclk_tab[t] : $urandom_range(24, 6);
            case (t)
                0:       next_word = 16'hFFFF;
                1:       next_word = 16'h0000;
                2:       next_word = 16'h8001;
                default: next_word = 16'($urandom());
            endcase
            conv_cycles = 8'($urandom_range(30, 1));
            frame(nclk, exp_word);
            // a start fall comes at clock 16, or at select high after clock 8
            if (nclk >= 8) begin
                exp_word = next_word;
            end
            $display("test %0d done: %0d clocks", t, nclk);
        end
        conclude();
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        $display("ERROR %0t run did not finish", $time);
        conclude();
    end
endmodule
